/* cat_top.sv */
// clock output selector and first timer with an Avalon-MM register slave
// Notes on behaviour
// - three-bit code picks clock output rate
// - square wave on both open-drain pins
// - rates below top one are 50:50
// - hold releases pins except three fastest rates
// - offset correction moves only 32 Hz, 1 Hz
// - three-bit code picks timer source tick
// - counter counts down from loaded value n
// - mode code: countdown, watchdog or off
// - watchdog flag sets at tick after one
// - watchdog interrupt only when its enable set
// - counter write clears watchdog flag, restarts
// - reading flag register clears watchdog flag
// - one bit picks pulse or level interrupt
// - countdown end sets flag, reloads, continues
// - countdown flag cleared only by host write
// - countdown flag writes AND: zero clears, one keeps
// - value read returns live counter
// - mid-period reload write takes effect at once
// - zero reload halts the countdown
// - first period spans n-1 to n ticks
// - countdown flag with enable drives interrupt
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module cat_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic OFFSET_SKIP,
  output logic CLOCK_OUTPUT_PIN_O,
  output logic CLOCK_OUTPUT_PIN_OE,
  output logic IRQ_CLK_PIN_O,
  output logic IRQ_CLK_PIN_OE
);
  ////////////////////////////////////////////////////////////////////////////
  // state and wires

  // whole state of the block
  typedef struct packed {
    cat_pkg::cat_bus_t bus; // slave answer state
    logic wait_req; // waitrequest, low for one answer cycle
    logic [31:0] rdata; // read data held for the answer
    logic wd_flag; // watchdog_timeout_flag
    logic cd_flag; // countdown_flag
    logic wd_ie; // watchdog_irq_enable
    logic cd_ie; // countdown_irq_enable
    logic pulse_mode; // first_timer_pulse_mode
    cat_pkg::cat_cof_t cof; // clock_output_freq_select
    cat_pkg::cat_mode_t mode; // first_timer_mode
    cat_pkg::cat_src_t src; // first_timer_source_select
    logic hold; // prescaler hold
    logic [7:0] reload; // stored n
    logic [7:0] count; // live counter
    logic irq_pulse; // pulse-mode interrupt window
    logic clk_oe; // clock pin pulls low
    logic int_oe; // shared pin pulls low
    logic pin_low; // open-drain data, always low
  } cat_top_st_t;
  cat_top_st_t s, next_s;

  logic [cat_pkg::CHAIN_W-1:0] chain; // prescaler chain
  logic [cat_pkg::SRC_N-1:0] ticks; // prescaler source ticks
  logic clk_pull; // clock selector wants the pins low
  logic [5:0] idx; // register index from byte address
  logic req; // master request present
  logic take; // request completes this edge
  logic wr_ok; // write to the low byte completes
  logic [7:0] wd; // written byte
  logic tick; // selected source tick
  logic cd_evt; // countdown period ended
  logic wd_evt; // watchdog timed out
  logic level; // enabled flags pending
  logic irq; // interrupt drive on the shared pin
  logic pulse_end; // end of pulse-mode window

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // read view of one register; unmapped indices read zero
  function automatic logic [7:0] rd_reg(input logic [5:0] i, input cat_top_st_t st);
    logic [7:0] r;
    r = '0;
    case (i)
      cat_pkg::REG_FLAGS: begin
        r[cat_pkg::FLG_WD] = st.wd_flag;
        r[cat_pkg::FLG_CD] = st.cd_flag;
        r[cat_pkg::FLG_WIE] = st.wd_ie;
        r[cat_pkg::FLG_CIE] = st.cd_ie;
      end
      cat_pkg::REG_CFG: begin
        r[cat_pkg::CFG_PULSE] = st.pulse_mode;
        r[cat_pkg::CFG_COF_LO+:3] = st.cof;
        r[cat_pkg::CFG_MODE_LO+:2] = st.mode;
      end
      cat_pkg::REG_SRC: r[2:0] = st.src;
      cat_pkg::REG_VAL: r = st.count; // live value, not n
      cat_pkg::REG_HOLD: r[cat_pkg::HOLD_BIT] = st.hold;
      default: r = '0;
    endcase
    rd_reg = r;
  endfunction

  // source tick for a source code; the unused code never ticks
  function automatic logic pick_tick(input cat_pkg::cat_src_t q, input logic [cat_pkg::SRC_N-1:0] t);
    logic p;
    p = 1'h0;
    unique case (q)
      cat_pkg::SRC_Q4K: p = t[cat_pkg::TK_4K];
      cat_pkg::SRC_Q64: p = t[cat_pkg::TK_64];
      cat_pkg::SRC_Q1: p = t[cat_pkg::TK_1];
      cat_pkg::SRC_QMIN: p = t[cat_pkg::TK_MIN];
      cat_pkg::SRC_QHR, cat_pkg::SRC_QHR6, cat_pkg::SRC_QHR7: p = t[cat_pkg::TK_HR];
      cat_pkg::SRC_QRSV: p = 1'h0;
    endcase
    pick_tick = p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sub-blocks

  // single chain feeds clock output and timer
  cat_prescaler u_pre (
    .clk(REF_CLK),
    .rst(SRST),
    .hold(s.hold),
    .offset_skip(OFFSET_SKIP),
    .chain(chain),
    .ticks(ticks)
  );

  // clock output tap and hold gate
  cat_clk_sel u_sel (
    .chain(chain),
    .cof(s.cof),
    .hold(s.hold),
    .pull(clk_pull)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign idx = AVS_ADDRESS[7:2];
  assign req = AVS_READ || AVS_WRITE;
  assign take = (s.bus == cat_pkg::BUS_ANSWER) && req;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // bus answer, register writes, timer and interrupt in one pass
  always_comb begin
    next_s = s;
    wr_ok = take && AVS_WRITE && AVS_BYTEENABLE[0];
    wd = AVS_WRITEDATA[7:0];
    tick = pick_tick(s.src, ticks);
    cd_evt = 1'h0;
    wd_evt = 1'h0;
    // answer one cycle after the request; data is sampled then and held
    unique case (s.bus)
      cat_pkg::BUS_IDLE: begin
        if (req) begin
          next_s.bus = cat_pkg::BUS_ANSWER;
          next_s.wait_req = 1'h0;
          next_s.rdata = {24'h000000, rd_reg(idx, s)};
        end
      end
      cat_pkg::BUS_ANSWER: begin
        next_s.bus = cat_pkg::BUS_IDLE;
        next_s.wait_req = 1'h1;
      end
    endcase
    // read clears only what it returned, so a later timeout is not lost
    if (take && AVS_READ && idx == cat_pkg::REG_FLAGS) begin
      next_s.wd_flag = s.wd_flag & ~s.rdata[cat_pkg::FLG_WD];
    end
    // register writes take effect at the completing edge
    if (wr_ok) begin
      case (idx)
        cat_pkg::REG_FLAGS: begin
          // the timeout flag is read only; the countdown flag is ANDed, both enables are written directly
          next_s.cd_flag = s.cd_flag & wd[cat_pkg::FLG_CD];
          next_s.wd_ie = wd[cat_pkg::FLG_WIE];
          next_s.cd_ie = wd[cat_pkg::FLG_CIE];
        end
        cat_pkg::REG_CFG: begin
          next_s.pulse_mode = wd[cat_pkg::CFG_PULSE];
          next_s.cof = cat_pkg::cat_cof_t'(wd[cat_pkg::CFG_COF_LO+:3]);
          next_s.mode = cat_pkg::cat_mode_t'(wd[cat_pkg::CFG_MODE_LO+:2]);
        end
        cat_pkg::REG_SRC: next_s.src = cat_pkg::cat_src_t'(wd[2:0]);
        cat_pkg::REG_VAL: begin
          // immediate load; no source-clock sync, so the host should stop first
          next_s.reload = wd;
          next_s.count = wd;
          next_s.wd_flag = 1'h0;
        end
        cat_pkg::REG_HOLD: next_s.hold = wd[cat_pkg::HOLD_BIT];
        default: next_s.hold = s.hold;
      endcase
    end
    // counter steps on the free-running source tick, so the first
    // period after a start lasts between n-1 and n ticks
    if (tick && !(wr_ok && idx == cat_pkg::REG_VAL)) begin
      if (s.mode == cat_pkg::MODE_COUNT && s.reload != '0) begin
        if (s.count == 8'h01) begin
          cd_evt = 1'h1;
          next_s.count = s.reload;
        end else if (s.count == 8'h00) begin
          next_s.count = s.reload;
        end else begin
          next_s.count = s.count - 8'h01;
        end
      end
      if (s.mode == cat_pkg::MODE_WATCH && s.count != '0) begin
        // no reload: the watchdog stops at zero after timing out
        if (s.count == 8'h01) begin
          wd_evt = 1'h1;
          next_s.count = 8'h00;
        end else begin
          next_s.count = s.count - 8'h01;
        end
      end
    end
    // hardware sets win over a clear in the same cycle
    if (cd_evt) begin
      next_s.cd_flag = 1'h1;
    end
    if (wd_evt) begin
      next_s.wd_flag = 1'h1;
    end
    // interrupt: pulse opens on an enabled event, closes at the next 4096 Hz tick for that source, else at the next 64 Hz tick
    level = (s.cd_ie && s.cd_flag) || (s.wd_ie && s.wd_flag);
    pulse_end = (s.src == cat_pkg::SRC_Q4K) ? ticks[cat_pkg::TK_4K] : ticks[cat_pkg::TK_64];
    if ((cd_evt && s.cd_ie) || (wd_evt && s.wd_ie)) begin
      next_s.irq_pulse = 1'h1;
    end else if (pulse_end) begin
      next_s.irq_pulse = 1'h0;
    end
    // clearing a flag also cuts a running pulse short
    irq = s.pulse_mode ? (s.irq_pulse && level) : level;
    // both pins carry the wave; the shared one also the interrupt
    next_s.clk_oe = clk_pull;
    next_s.int_oe = clk_pull || irq;
    next_s.pin_low = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset to documented defaults
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s <= '0;
      s.bus <= cat_pkg::BUS_IDLE;
      s.wait_req <= 1'h1;
      s.cof <= cat_pkg::COF_RESET;
      s.mode <= cat_pkg::MODE_RESET;
      s.src <= cat_pkg::SRC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign AVS_READDATA = s.rdata;
  assign AVS_WAITREQUEST = s.wait_req;
  assign CLOCK_OUTPUT_PIN_O = s.pin_low;
  assign CLOCK_OUTPUT_PIN_OE = s.clk_oe;
  assign IRQ_CLK_PIN_O = s.pin_low;
  assign IRQ_CLK_PIN_OE = s.int_oe;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  // disabled output never pulls the clock pin
  a_cof_off_quiet:
    assert property ($past(s.cof) == cat_pkg::COF_OFF |-> !s.clk_oe)
    else $error("clock pin pulled while output disabled");

  // hold releases the clock pin for the slow rates
  a_hold_slow_release:
    assert property ($past(s.hold) && $past(s.cof) inside {cat_pkg::COF_4K, cat_pkg::COF_1K,
      cat_pkg::COF_32, cat_pkg::COF_1} |-> !s.clk_oe)
    else $error("clock pin pulled during hold at slow rate");

  // timeout sets the watchdog flag at the next edge
  a_wd_flag_set:
    assert property (wd_evt |=> s.wd_flag && s.count == 8'h00)
    else $error("watchdog timeout did not set flag");

  // no enables and no clock output leave the shared pin released
  a_irq_gated:
    assert property ($past(s.cof == cat_pkg::COF_OFF && !s.wd_ie && !s.cd_ie) |-> !s.int_oe)
    else $error("interrupt pin pulled with interrupts disabled");

  // a counter write clears a stale timeout
  a_wr_clear_wd:
    assert property (wr_ok && idx == cat_pkg::REG_VAL && !wd_evt |=> !s.wd_flag && s.count == $past(wd))
    else $error("counter write did not clear watchdog flag");

  // reading the flag register clears a returned timeout
  a_rd_clear_wd:
    assert property (take && AVS_READ && idx == cat_pkg::REG_FLAGS && s.rdata[cat_pkg::FLG_WD] && !wd_evt
      |=> !s.wd_flag)
    else $error("flag read did not clear watchdog flag");

  // countdown end reloads n and raises the flag
  a_cd_reload:
    assert property (cd_evt && !wr_ok |=> s.count == $past(s.reload) && s.cd_flag)
    else $error("countdown end did not reload");

  // countdown flag only falls through a flag write
  a_cd_sticky:
    assert property (s.cd_flag && !(wr_ok && idx == cat_pkg::REG_FLAGS) |=> s.cd_flag)
    else $error("countdown flag cleared without a write");

  // a written zero clears the countdown flag
  a_and_write:
    assert property (wr_ok && idx == cat_pkg::REG_FLAGS && !wd[cat_pkg::FLG_CD] && !cd_evt |=> !s.cd_flag)
    else $error("flag write of zero did not clear");

  // value read returns the live counter
  a_read_live:
    assert property (s.bus == cat_pkg::BUS_IDLE && req && idx == cat_pkg::REG_VAL
      |=> s.rdata[7:0] == $past(s.count) && !s.wait_req ##1 s.wait_req)
    else $error("value read not the live counter");

  // zero reload keeps the countdown halted
  a_zero_halt:
    assert property (s.mode == cat_pkg::MODE_COUNT && s.reload == 8'h00 && s.count == 8'h00 && !wr_ok
      |=> s.count == 8'h00 && !$rose(s.cd_flag))
    else $error("countdown ran with zero reload");
endmodule
`default_nettype wire

/* cat_pkg.sv */
// constants, encodings and field layout for the clock output and first timer
package cat_pkg;
  // rates
  localparam int unsigned CLK_HZ = 100_000_000; // system clock rate
  localparam int unsigned OSC_HZ = 32_768; // oscillator rate
  localparam int unsigned CHAIN_HZ = 2 * OSC_HZ; // chain steps twice per oscillator period
  localparam logic [31:0] NCO_MOD = 32'(CLK_HZ); // accumulator modulus
  localparam logic [31:0] NCO_STEP = 32'(CHAIN_HZ); // accumulator increment
  // prescaler chain taps: bit k toggles at CHAIN_HZ / 2^(k+1)
  localparam int CHAIN_W = 16;
  localparam logic [CHAIN_W-1:0] CHAIN_ONE = 16'h0001;
  localparam int TAP_32K = 0;
  localparam int TAP_16K = 1;
  localparam int TAP_8K = 2;
  localparam int TAP_4K = 3;
  localparam int TAP_1K = 5;
  localparam int TAP_64 = 9;
  localparam int TAP_32 = 10;
  localparam int TAP_1 = 15;
  localparam int HOLD_LO = TAP_4K; // lowest chain bit held by the hold gate
  localparam int OFFS_LO = TAP_32; // lowest chain bit moved by offset correction
  localparam logic [5:0] SIXTY_LAST = 6'h3B; // last count of a sixty counter
  // source tick vector positions
  localparam int TK_4K = 0;
  localparam int TK_64 = 1;
  localparam int TK_1 = 2;
  localparam int TK_MIN = 3;
  localparam int TK_HR = 4;
  localparam int SRC_N = 5;
  // register indices; byte address is four times the index
  localparam logic [5:0] REG_FLAGS = 6'h01;
  localparam logic [5:0] REG_CFG = 6'h0F;
  localparam logic [5:0] REG_SRC = 6'h10;
  localparam logic [5:0] REG_VAL = 6'h11;
  localparam logic [5:0] REG_HOLD = 6'h14;
  // field positions
  localparam int FLG_WD = 7; // watchdog_timeout_flag
  localparam int FLG_CD = 6; // countdown_flag
  localparam int FLG_WIE = 2; // watchdog_irq_enable
  localparam int FLG_CIE = 1; // countdown_irq_enable
  localparam int CFG_PULSE = 7; // first_timer_pulse_mode
  localparam int CFG_COF_LO = 3; // clock_output_freq_select
  localparam int CFG_MODE_LO = 1; // first_timer_mode
  localparam int HOLD_BIT = 0; // prescaler hold
  // encodings
  typedef enum logic [2:0] {
    COF_32K = 3'h0, COF_16K = 3'h1, COF_8K = 3'h2, COF_4K = 3'h3,
    COF_1K = 3'h4, COF_32 = 3'h5, COF_1 = 3'h6, COF_OFF = 3'h7
  } cat_cof_t;
  typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_COUNT = 2'h1, MODE_WATCH = 2'h2, MODE_SPARE = 2'h3} cat_mode_t;
  typedef enum logic [2:0] {
    SRC_Q4K = 3'h0, SRC_Q64 = 3'h1, SRC_Q1 = 3'h2, SRC_QMIN = 3'h3,
    SRC_QHR = 3'h4, SRC_QRSV = 3'h5, SRC_QHR6 = 3'h6, SRC_QHR7 = 3'h7
  } cat_src_t;
  typedef enum logic {BUS_IDLE = 1'h0, BUS_ANSWER = 1'h1} cat_bus_t;
  // reset values
  localparam cat_cof_t COF_RESET = COF_32K;
  localparam cat_mode_t MODE_RESET = MODE_OFF;
  localparam cat_src_t SRC_RESET = SRC_Q4K;
endpackage

/* cat_prescaler.sv */
// oscillator step generator, binary prescaler chain and timer source ticks
`timescale 1ns/1ns
`default_nettype none
module cat_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic offset_skip,
  output logic [cat_pkg::CHAIN_W-1:0] chain,
  output logic [cat_pkg::SRC_N-1:0] ticks
);
  // whole state of the prescaler
  typedef struct packed {
    logic [31:0] acc; // fractional step accumulator
    logic [cat_pkg::CHAIN_W-1:0] chain; // binary chain
    logic [5:0] sec; // seconds within a minute
    logic [5:0] min; // minutes within an hour
    logic [cat_pkg::SRC_N-1:0] ticks; // one-cycle source pulses
  } cat_pre_st_t;
  cat_pre_st_t s, next_s;
  logic [31:0] sum; // accumulator before wrap
  logic step; // one chain step this cycle

  // rising edge of chain bit k on the coming step
  function automatic logic rise(input logic [cat_pkg::CHAIN_W-1:0] c, input int k);
    logic [cat_pkg::CHAIN_W-1:0] mask;
    mask = (cat_pkg::CHAIN_ONE << k) - cat_pkg::CHAIN_ONE;
    rise = ((c & mask) == mask) && !c[k];
  endfunction

  // next state: the chain only steps at twice the oscillator rate
  always_comb begin
    next_s = s;
    sum = s.acc + cat_pkg::NCO_STEP;
    step = (sum >= cat_pkg::NCO_MOD);
    next_s.acc = step ? sum - cat_pkg::NCO_MOD : sum;
    next_s.ticks = '0;
    if (step && !hold) begin
      next_s.ticks[cat_pkg::TK_4K] = rise(s.chain, cat_pkg::TAP_4K);
      next_s.ticks[cat_pkg::TK_64] = rise(s.chain, cat_pkg::TAP_64);
      // a swallowed carry also swallows the slow ticks
      next_s.ticks[cat_pkg::TK_1] = rise(s.chain, cat_pkg::TAP_1) && !offset_skip;
      next_s.ticks[cat_pkg::TK_MIN] = next_s.ticks[cat_pkg::TK_1] && (s.sec == cat_pkg::SIXTY_LAST);
      next_s.ticks[cat_pkg::TK_HR] = next_s.ticks[cat_pkg::TK_MIN] && (s.min == cat_pkg::SIXTY_LAST);
    end
    if (step) begin
      next_s.chain[cat_pkg::HOLD_LO-1:0] = s.chain[cat_pkg::HOLD_LO-1:0] + 1'h1;
      if (&s.chain[cat_pkg::HOLD_LO-1:0]) begin
        next_s.chain[cat_pkg::OFFS_LO-1:cat_pkg::HOLD_LO] = s.chain[cat_pkg::OFFS_LO-1:cat_pkg::HOLD_LO] + 1'h1;
      end
      // offset correction drops one carry into the slow part
      if ((&s.chain[cat_pkg::OFFS_LO-1:0]) && !offset_skip) begin
        next_s.chain[cat_pkg::CHAIN_W-1:cat_pkg::OFFS_LO] = s.chain[cat_pkg::CHAIN_W-1:cat_pkg::OFFS_LO] + 1'h1;
      end
      if (next_s.ticks[cat_pkg::TK_1]) begin
        next_s.sec = (s.sec == cat_pkg::SIXTY_LAST) ? '0 : s.sec + 1'h1;
      end
      if (next_s.ticks[cat_pkg::TK_MIN]) begin
        next_s.min = (s.min == cat_pkg::SIXTY_LAST) ? '0 : s.min + 1'h1;
      end
    end
    // hold keeps the upper chain in reset, the fast taps keep running
    if (hold) begin
      next_s.chain[cat_pkg::CHAIN_W-1:cat_pkg::HOLD_LO] = '0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign chain = s.chain;
  assign ticks = s.ticks;
endmodule
`default_nettype wire

/* cat_clk_sel.sv */
// selects the clock output tap and decides when the open-drain pin pulls low
`timescale 1ns/1ns
`default_nettype none
module cat_clk_sel (
  input wire logic [cat_pkg::CHAIN_W-1:0] chain,
  input wire cat_pkg::cat_cof_t cof,
  input wire logic hold,
  output logic pull
);
  logic tap; // selected square wave
  logic slow; // tap stops under hold
  logic on; // output enabled

  // tap decode; every chain bit is a toggle, so all but the top rate are 50:50
  always_comb begin
    tap = 1'h1;
    slow = 1'h1;
    on = 1'h1;
    unique case (cof)
      cat_pkg::COF_32K: begin tap = chain[cat_pkg::TAP_32K]; slow = 1'h0; end
      cat_pkg::COF_16K: begin tap = chain[cat_pkg::TAP_16K]; slow = 1'h0; end
      cat_pkg::COF_8K: begin tap = chain[cat_pkg::TAP_8K]; slow = 1'h0; end
      cat_pkg::COF_4K: tap = chain[cat_pkg::TAP_4K];
      cat_pkg::COF_1K: tap = chain[cat_pkg::TAP_1K];
      cat_pkg::COF_32: tap = chain[cat_pkg::TAP_32];
      cat_pkg::COF_1: tap = chain[cat_pkg::TAP_1];
      cat_pkg::COF_OFF: on = 1'h0;
    endcase
    // open drain: pull only while the wave is low
    pull = on && !(slow && hold) && !tap;
  end
endmodule
`default_nettype wire

/* cat_pullup.sv */
// board-side pull-up model for the two open-drain pins of the block
`timescale 1ns/1ns
`default_nettype none
module cat_pullup (
  input wire logic o,
  input wire logic oe,
  output logic pin
);
  // a released pin floats up to the pull-up level, it never keeps the last driven value
  assign pin = oe ? o : 1'h1;
endmodule
`default_nettype wire

/* clock_output_pin_and_timer_a_tb_top.sv */
// register-level testbench for the clock output selector and the first timer
`timescale 1ns/1ns
`default_nettype none
module clock_output_pin_and_timer_a_tb_top;
  logic ref_clk = 1'h0; // 100 MHz system clock
  logic srst = 1'h1; // synchronous reset, active high
  logic [7:0] adr = 8'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic wait_req;
  logic ck_o, ck_oe, iq_o, iq_oe; // open-drain halves from the block
  logic ck_pin, iq_pin; // resolved pin levels
  logic [7:0] q;
  logic hit;
  int error_cnt = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock: inverted every half period
  always #5 ref_clk = ~ref_clk;
  cat_top i_dut (.REF_CLK(ref_clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .OFFSET_SKIP(1'h0), .CLOCK_OUTPUT_PIN_O(ck_o), .CLOCK_OUTPUT_PIN_OE(ck_oe),
    .IRQ_CLK_PIN_O(iq_o), .IRQ_CLK_PIN_OE(iq_oe));
  cat_pullup i_ck_pull (.o(ck_o), .oe(ck_oe), .pin(ck_pin));
  cat_pullup i_iq_pull (.o(iq_o), .oe(iq_oe), .pin(iq_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // compare one value against its expectation
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one Avalon access; request held until the rising edge that samples waitrequest low
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, d};
    // no limit of its own: a slave that never answers is caught by the watchdog
    do begin
      @(posedge ref_clk);
    end while (wait_req !== 1'h0);
    // read data stands at the same edge as the answer
    r = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    // idle cycle so the next request is not assigned in the same time step
    @(posedge ref_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'h1, a, d, r);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    acc(1'h0, a, 8'h00, q);
  endtask
  // bounded search for a pin level; ends early once seen
  task automatic seek(input logic irq, input logic lvl, input int lim);
    hit = 1'h0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge ref_clk);
      if ((irq ? iq_pin : ck_pin) === lvl) hit = 1'h1;
    end
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need about 61k cycles, most of it waiting on 4096 Hz ticks
  initial begin
    #950000;
    error_cnt++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [7:0] regs [6];
    regs = '{8'h04, 8'h3C, 8'h40, 8'h44, 8'h50, 8'h08};
    repeat (6) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    // reset values, unmapped address last
    foreach (regs[i]) begin
      rd_reg(regs[i]);
      chk(q, 8'h00);
    end
    // default code drives a wave on both pins
    seek(1'h0, 1'h0, 4000);
    chk({7'h00, hit}, 8'h01);
    seek(1'h0, 1'h1, 4000);
    chk({7'h00, hit}, 8'h01);
    seek(1'h1, 1'h0, 4000);
    chk({7'h00, hit}, 8'h01);
    // hold: fastest rate keeps running, 4096 Hz is released
    wr_reg(8'h50, 8'h01);
    seek(1'h0, 1'h0, 4000);
    chk({7'h00, hit}, 8'h01);
    wr_reg(8'h3C, 8'h18);
    repeat (3) @(posedge ref_clk);
    seek(1'h0, 1'h0, 2000);
    chk({7'h00, hit}, 8'h00);
    seek(1'h1, 1'h0, 2000);
    chk({7'h00, hit}, 8'h00);
    // output off code; hold released so the timer ticks again
    wr_reg(8'h50, 8'h00);
    wr_reg(8'h3C, 8'h38);
    repeat (3) @(posedge ref_clk);
    seek(1'h0, 1'h0, 2000);
    chk({7'h00, hit}, 8'h00);
    // counter value read twice while the timer is off
    wr_reg(8'h44, 8'h05);
    rd_reg(8'h44);
    chk(q, 8'h05);
    rd_reg(8'h44);
    chk(q, 8'h05);
    // countdown n=1 at 4096 Hz, level interrupt; n changed only while stopped
    wr_reg(8'h04, 8'h02);
    wr_reg(8'h44, 8'h01);
    wr_reg(8'h3C, 8'h3A);
    seek(1'h1, 1'h0, 30000);
    chk({7'h00, hit}, 8'h01);
    rd_reg(8'h04);
    chk(q, 8'h42);
    rd_reg(8'h44);
    chk(q, 8'h01);
    wr_reg(8'h04, 8'h02);
    rd_reg(8'h04);
    chk(q, 8'h02);
    chk({7'h00, iq_pin}, 8'h01);
    wr_reg(8'h3C, 8'h38);
    // watchdog n=1 with its interrupt enabled, pulse mode
    wr_reg(8'h04, 8'h04);
    wr_reg(8'h3C, 8'hBC);
    wr_reg(8'h44, 8'h01);
    seek(1'h1, 1'h0, 30000);
    chk({7'h00, hit}, 8'h01);
    // pulse ends at the next source tick while the flag still stands
    seek(1'h1, 1'h1, 30000);
    chk({7'h00, hit}, 8'h01);
    rd_reg(8'h04);
    chk(q, 8'h84);
    rd_reg(8'h04);
    chk(q, 8'h04);
    chk({7'h00, iq_pin}, 8'h01);
    rd_reg(8'h44);
    chk(q, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
